//--- rtl/ddt_timer.sv
// dual down-counter timer: register interface, counters, interrupts
//
// Functional notes
// - direct load write replaces count on qualified edge
// - periodic mode reloads stored value at zero
// - background write changes stored value only
// - both writes, background last: immediate first, background for reloads
// - load read returns next reload value
// - background read equals load read
// - current value is read-only live count
// - control bit 7 enables counting
// - control bit 6 selects periodic mode
// - control bit 5 enables interrupt, default on
// - bits 3:2 prescale by 1, 16, 256
// - control bit 1 selects 32-bit counting
// - control bits 31:8 read as zero
// - clear write drops latched interrupt unless a zero hit sets it in the same cycle
// - raw status bit 0 is unmasked interrupt
// - masked status equals raw AND enable
// - test control bit 0 enters test mode
// - test output bits drive counter interrupts
// - combined output is OR of both counter interrupts
// - interrupt latches at zero until cleared
// - counting advances only on qualified edges
`timescale 1ns/1ps
`default_nettype none
`include "ddt_timer_regs.svh"

module ddt_timer (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [1:0] COUNTER_TICK_QUALIFIER_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    output logic FIRST_COUNTER_IRQ_O,
    output logic SECOND_COUNTER_IRQ_O,
    output logic COMBINED_COUNTER_IRQ_O
);

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    ddt_pkg::ddt_ctrl_t ctrl_r [0:1];
    logic [31:0] load_r [0:1];
    logic [31:0] imm_val_r [0:1];
    logic imm_pend_r [0:1];
    logic raw_r [0:1];
    logic itcr_r;
    logic [1:0] itop_r;
    logic [1:0] irq_r;
    logic comb_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;

    logic [31:0] count [0:1];
    logic [1:0] zero_hit;
    logic [1:0] imm_take;
    logic [1:0] tick;
    logic [1:0] irq_nxt;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    logic wr_access;
    logic rd_setup;
    logic tmr_hit;
    logic tsel;
    logic [4:0] off;
    logic [1:0] tmr_wr;
    logic [31:0] rd_nxt;

    assign wr_access = PSEL_I && PENABLE_I && PWRITE_I;
    assign rd_setup = PSEL_I && !PENABLE_I && !PWRITE_I;
    assign tmr_hit = (PADDR_I[11:6] == 6'h00);
    assign tsel = (PADDR_I & `DDT_TMR2_BASE) != 12'h000;
    assign off = PADDR_I[4:0];
    assign tmr_wr[0] = wr_access && tmr_hit && !tsel;
    assign tmr_wr[1] = wr_access && tmr_hit && tsel;

    // ----------------------------------------------------------------
    // per-counter registers and counters
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_tmr

            // control register
            always_ff @(posedge CLK_I) begin
                if (RST_I) begin
                    ctrl_r[gi] <= ddt_pkg::ddt_ctrl_t'(`DDT_CTRL_RST);
                end else if (tmr_wr[gi] && off == `DDT_OFF_CTRL) begin
                    ctrl_r[gi] <= ddt_pkg::ddt_ctrl_t'(PWDATA_I[7:0]);
                end
            end

            // shared load storage: both load registers write it
            always_ff @(posedge CLK_I) begin
                if (RST_I) begin
                    load_r[gi] <= `DDT_LOAD_RST;
                end else if (tmr_wr[gi] && (off == `DDT_OFF_LOAD || off == `DDT_OFF_BGLOAD)) begin
                    load_r[gi] <= PWDATA_I;
                end
            end

            // immediate load value and its pending flag; a new write wins
            always_ff @(posedge CLK_I) begin
                if (RST_I) begin
                    imm_val_r[gi] <= `DDT_LOAD_RST;
                    imm_pend_r[gi] <= 1'b0;
                end else if (tmr_wr[gi] && off == `DDT_OFF_LOAD) begin
                    imm_val_r[gi] <= PWDATA_I;
                    imm_pend_r[gi] <= 1'b1;
                end else if (imm_take[gi]) begin
                    imm_pend_r[gi] <= 1'b0;
                end
            end

            // raw interrupt latch: set beats clear
            always_ff @(posedge CLK_I) begin
                if (RST_I) begin
                    raw_r[gi] <= 1'b0;
                end else if (zero_hit[gi]) begin
                    raw_r[gi] <= 1'b1;
                end else if (tmr_wr[gi] && off == `DDT_OFF_INTCLR) begin
                    raw_r[gi] <= 1'b0;
                end
            end

            // interrupt output source: test value or masked raw
            assign irq_nxt[gi] = itcr_r ? itop_r[gi] : (raw_r[gi] && ctrl_r[gi].irq_en);

            ddt_prescale u_pre (
                .clk_i(CLK_I),
                .rst_i(RST_I),
                .qual_i(COUNTER_TICK_QUALIFIER_I[gi]),
                .run_i(ctrl_r[gi].enable),
                .sel_i(ctrl_r[gi].prescale_select),
                .tick_o(tick[gi])
            );

            ddt_counter u_cnt (
                .clk_i(CLK_I),
                .rst_i(RST_I),
                .qual_i(COUNTER_TICK_QUALIFIER_I[gi]),
                .tick_i(tick[gi]),
                .ctrl_i(ctrl_r[gi]),
                .load_i(load_r[gi]),
                .imm_pend_i(imm_pend_r[gi]),
                .imm_val_i(imm_val_r[gi]),
                .count_o(count[gi]),
                .zero_o(zero_hit[gi]),
                .imm_take_o(imm_take[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // integration test registers
    // ----------------------------------------------------------------

    // test mode enable and test output value
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            itcr_r <= 1'b0;
            itop_r <= 2'b00;
        end else if (wr_access && PADDR_I == `DDT_OFF_ITCR) begin
            itcr_r <= PWDATA_I[`DDT_ITCR_EN_BIT];
        end else if (wr_access && PADDR_I == `DDT_OFF_ITOP) begin
            itop_r <= PWDATA_I[`DDT_ITOP_WIDTH-1:0];
        end
    end

    // ----------------------------------------------------------------
    // interrupt outputs
    // ----------------------------------------------------------------

    // registered per-counter and combined interrupts
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            irq_r <= 2'b00;
            comb_r <= 1'b0;
        end else begin
            irq_r <= irq_nxt;
            comb_r <= |irq_nxt;
        end
    end

    assign FIRST_COUNTER_IRQ_O = irq_r[0];
    assign SECOND_COUNTER_IRQ_O = irq_r[1];
    assign COMBINED_COUNTER_IRQ_O = comb_r;

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------

    // read mux; unmapped and write-only locations read zero
    always_comb begin
        rd_nxt = 32'h00000000;
        if (tmr_hit) begin
            unique case (off)
                `DDT_OFF_LOAD: rd_nxt = load_r[tsel];
                `DDT_OFF_BGLOAD: rd_nxt = load_r[tsel];
                `DDT_OFF_VALUE: rd_nxt = count[tsel];
                `DDT_OFF_CTRL: rd_nxt = {24'h000000, ctrl_r[tsel]};
                `DDT_OFF_RIS: rd_nxt = {31'h00000000, raw_r[tsel]};
                `DDT_OFF_MIS: rd_nxt = {31'h00000000, raw_r[tsel] && ctrl_r[tsel].irq_en};
                default: rd_nxt = 32'h00000000;
            endcase
        end else if (PADDR_I == `DDT_OFF_ITCR) begin
            rd_nxt = {31'h00000000, itcr_r};
        end
    end

    // read data captured in the setup phase, held for the access phase
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            prdata_r <= 32'h00000000;
        end else if (rd_setup) begin
            prdata_r <= rd_nxt;
        end
    end

    // zero-wait, never-error response
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            pready_r <= 1'b1;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= 1'b1;
            pslverr_r <= 1'b0;
        end
    end

    assign PRDATA_O = prdata_r;
    assign PREADY_O = pready_r;
    assign PSLVERR_O = pslverr_r;

endmodule
`default_nettype wire

//--- rtl/ddt_timer_regs.svh
// constants for the dual down-counter timer: offsets, resets, fields
`ifndef DDT_TIMER_REGS_SVH
`define DDT_TIMER_REGS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define DDT_OFF_LOAD 5'h00
`define DDT_OFF_VALUE 5'h04
`define DDT_OFF_CTRL 5'h08
`define DDT_OFF_INTCLR 5'h0C
`define DDT_OFF_RIS 5'h10
`define DDT_OFF_MIS 5'h14
`define DDT_OFF_BGLOAD 5'h18
`define DDT_TMR2_BASE 12'h020
`define DDT_OFF_ITCR 12'hF00
`define DDT_OFF_ITOP 12'hF04

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DDT_LOAD_RST 32'h00000000
`define DDT_VALUE_RST 32'hFFFFFFFF
`define DDT_CTRL_RST 8'h20

// ----------------------------------------------------------------
// fields and counts
// ----------------------------------------------------------------
`define DDT_ITCR_EN_BIT 0
`define DDT_ITOP_WIDTH 2
`define DDT_CTRL_WIDTH 8
`define DDT_HALF_MASK 32'h0000FFFF
`define DDT_DIV16_LAST 8'h0F
`define DDT_DIV256_LAST 8'hFF

`endif

//--- rtl/ddt_pkg.sv
// types shared by the dual down-counter timer modules
package ddt_pkg;

    // prescale selection codes
    typedef enum logic [1:0] {
        DDT_DIV1 = 2'b00,
        DDT_DIV16 = 2'b01,
        DDT_DIV256 = 2'b10,
        DDT_DIVBAD = 2'b11
    } ddt_pre_t;

    // control register laid out at its bit positions
    typedef struct packed {
        logic enable;
        logic periodic;
        logic irq_en;
        logic spare;
        ddt_pre_t prescale_select;
        logic size32;
        logic one_shot;
    } ddt_ctrl_t;

endpackage

//--- rtl/ddt_prescale.sv
// prescaler: turns qualified timer edges into count ticks
`timescale 1ns/1ps
`default_nettype none
`include "ddt_timer_regs.svh"

module ddt_prescale (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic qual_i,
    input wire logic run_i,
    input wire ddt_pkg::ddt_pre_t sel_i,
    output logic tick_o
);

    logic [7:0] pre_cnt_r;

    // stage counter, advances only on qualified edges
    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            pre_cnt_r <= 8'h00;
        end else if (qual_i) begin
            pre_cnt_r <= pre_cnt_r + 8'h01;
        end
    end

    // tick selection; the unused code behaves as divide by 256
    always_comb begin
        unique case (sel_i)
            ddt_pkg::DDT_DIV1: tick_o = qual_i;
            ddt_pkg::DDT_DIV16: tick_o = qual_i && ({4'h0, pre_cnt_r[3:0]} == `DDT_DIV16_LAST);
            default: tick_o = qual_i && (pre_cnt_r == `DDT_DIV256_LAST);
        endcase
    end

endmodule
`default_nettype wire

//--- rtl/ddt_counter.sv
// one decrementing counter with load, wrap, reload and halt
`timescale 1ns/1ps
`default_nettype none
`include "ddt_timer_regs.svh"

module ddt_counter (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic qual_i,
    input wire logic tick_i,
    input wire ddt_pkg::ddt_ctrl_t ctrl_i,
    input wire logic [31:0] load_i,
    input wire logic imm_pend_i,
    input wire logic [31:0] imm_val_i,
    output logic [31:0] count_o,
    output logic zero_o,
    output logic imm_take_o
);

    logic [31:0] count_r;
    logic [31:0] count_nxt;
    logic low_zero;
    logic low_one;
    logic step;

    // zero and one detection over the selected width
    always_comb begin
        if (ctrl_i.size32) begin
            low_zero = (count_r == 32'h00000000);
            low_one = (count_r == 32'h00000001);
        end else begin
            low_zero = ((count_r & `DDT_HALF_MASK) == 32'h00000000);
            low_one = ((count_r & `DDT_HALF_MASK) == 32'h00000001);
        end
    end

    // a step happens when enabled, ticked and not halted
    assign step = ctrl_i.enable && tick_i && !(ctrl_i.one_shot && low_zero);
    assign imm_take_o = qual_i && imm_pend_i;

    // next value: reload, wrap or decrement
    always_comb begin
        if (low_zero && ctrl_i.periodic) begin
            count_nxt = load_i;
        end else if (low_zero) begin
            count_nxt = ctrl_i.size32 ? 32'hFFFFFFFF : (count_r | `DDT_HALF_MASK);
        end else if (ctrl_i.size32) begin
            count_nxt = count_r - 32'h00000001;
        end else begin
            count_nxt = {count_r[31:16], count_r[15:0] - 16'h0001};
        end
    end

    // counter register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_r <= `DDT_VALUE_RST;
        end else if (imm_take_o) begin
            count_r <= imm_val_i;
        end else if (step) begin
            count_r <= count_nxt;
        end
    end

    assign count_o = count_r;
    assign zero_o = step && low_one && !imm_take_o;

endmodule
`default_nettype wire

//--- test/ddt_timer_checker.sv
// assertion checker for the dual down-counter timer ports
`timescale 1ns/1ps
`default_nettype none
module ddt_timer_checker (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [1:0] COUNTER_TICK_QUALIFIER_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic FIRST_COUNTER_IRQ_O,
    input wire logic SECOND_COUNTER_IRQ_O,
    input wire logic COMBINED_COUNTER_IRQ_O
);
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RST_I);
    logic wr;
    logic rs;
    logic nt;
    logic itm_r;
    logic itm_d_r;
    logic [1:0] t1_r;
    logic [1:0] t2_r;
    // bus phase decode, settled test mode
    always_comb begin
        wr = PSEL_I && PENABLE_I && PWRITE_I;
        rs = PSEL_I && !PENABLE_I && !PWRITE_I;
        nt = !itm_r && !itm_d_r;
    end
    // test mode copy and recent writes that may drop an irq
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            itm_r <= 1'h0;
            itm_d_r <= 1'h0;
            t1_r <= 2'h0;
            t2_r <= 2'h0;
        end else begin
            if (wr && PADDR_I == 12'hF00) begin
                itm_r <= PWDATA_I[0];
            end
            itm_d_r <= itm_r;
            t1_r <= {t1_r[0], wr && PADDR_I inside {12'h008, 12'h00C, 12'hF00, 12'hF04}};
            t2_r <= {t2_r[0], wr && PADDR_I inside {12'h028, 12'h02C, 12'hF00, 12'hF04}};
        end
    end
    AST_READY: assert property (PREADY_O && !PSLVERR_O)
        else $error("bus ready or error flag wrong");
    AST_COMB: assert property (
        COMBINED_COUNTER_IRQ_O == (FIRST_COUNTER_IRQ_O | SECOND_COUNTER_IRQ_O))
        else $error("combined irq not the or of both");
    AST_ITOP: assert property (
        wr && PADDR_I == 12'hF04 && itm_r && itm_d_r |-> ##2
        FIRST_COUNTER_IRQ_O == $past(PWDATA_I[0], 2) && SECOND_COUNTER_IRQ_O == $past(PWDATA_I[1], 2))
        else $error("test output bits not on irq pins");
    AST_FALL1: assert property ($fell(FIRST_COUNTER_IRQ_O) |-> t1_r != 2'h0)
        else $error("first irq dropped without a clear");
    AST_FALL2: assert property ($fell(SECOND_COUNTER_IRQ_O) |-> t2_r != 2'h0)
        else $error("second irq dropped without a clear");
    AST_MASK: assert property (
        wr && PADDR_I == 12'h008 && !PWDATA_I[5] && nt |-> ##2 !FIRST_COUNTER_IRQ_O)
        else $error("masked irq still high");
    AST_CTLRSV: assert property (
        rs && PADDR_I inside {12'h008, 12'h028} |=> PRDATA_O[31:8] == 24'h0)
        else $error("control upper bits not zero");
    AST_STATRSV: assert property (
        rs && PADDR_I inside {12'h010, 12'h014, 12'h030, 12'h034} |=> PRDATA_O[31:1] == 31'h0)
        else $error("status upper bits not zero");
    AST_UNMAP: assert property (rs && PADDR_I inside {12'h040, 12'hF04} |=> PRDATA_O == 32'h0)
        else $error("unmapped read not zero");
    AST_MIS: assert property (
        rs && PADDR_I == 12'h014 && nt |=> PRDATA_O[0] == FIRST_COUNTER_IRQ_O)
        else $error("masked status differs from irq pin");
    COV_IRQ: cover property (nt && $rose(FIRST_COUNTER_IRQ_O));
    COV_ITOP: cover property (wr && PADDR_I == 12'hF04 && itm_r);
    COV_MIS: cover property (rs && PADDR_I == 12'h014 ##1 PRDATA_O[0]);
endmodule
bind ddt_timer ddt_timer_checker u_chk (.CLK_I(CLK_I), .RST_I(RST_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
    .COUNTER_TICK_QUALIFIER_I(COUNTER_TICK_QUALIFIER_I), .PRDATA_O(PRDATA_O),
    .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .FIRST_COUNTER_IRQ_O(FIRST_COUNTER_IRQ_O),
    .SECOND_COUNTER_IRQ_O(SECOND_COUNTER_IRQ_O), .COMBINED_COUNTER_IRQ_O(COMBINED_COUNTER_IRQ_O));
`default_nettype wire

//--- test/ddt_apb_host.sv
// software-side register bus master for the timer
`timescale 1ns/1ps
`default_nettype none
module ddt_apb_host (
    input wire logic clk_i,
    input wire logic pready_i,
    input wire logic [31:0] prdata_i,
    output logic psel_o = 1'h0,
    output logic penable_o = 1'h0,
    output logic pwrite_o = 1'h0,
    output logic [11:0] paddr_o = 12'h0,
    output logic [31:0] pwdata_o = 32'h0
);
    // one transfer: setup, access held until ready, then idle
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(negedge clk_i);
        psel_o = 1'h1;
        pwrite_o = w;
        paddr_o = a;
        pwdata_o = d;
        @(negedge clk_i);
        penable_o = 1'h1;
        @(posedge clk_i);
        while (pready_i !== 1'h1) begin
            @(posedge clk_i);
        end
        q = prdata_i;
        @(negedge clk_i);
        psel_o = 1'h0;
        penable_o = 1'h0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'h1, a, d, q);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] q);
        xfer(1'h0, a, 32'h0, q);
    endtask
    // control write keeping the spare bit and a legal prescale code
    task automatic setctl(input logic [11:0] b, input logic [7:0] v);
        logic [31:0] old;
        logic [7:0] nv;
        rd(b + 12'h008, old);
        nv = v;
        if (nv[3:2] == 2'h3) nv[3:2] = 2'h2;
        nv[4] = old[4];
        wr(b + 12'h008, {24'h0, nv});
    endtask
endmodule
`default_nettype wire

//--- test/tb_top.sv
// self-checking testbench for the dual down-counter timer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic [1:0] qual = 2'h0;
    logic psel, pen, pwr, pready, pslverr, irq1, irq2, comb;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    int err_total = 0;
    int check_count = 0;
    // clock at 100 MHz
    always #5 clk = ~clk;
    ddt_apb_host host (.clk_i(clk), .pready_i(pready), .prdata_i(prdata), .psel_o(psel),
        .penable_o(pen), .pwrite_o(pwr), .paddr_o(paddr), .pwdata_o(pwdata));
    ddt_timer DUT (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .COUNTER_TICK_QUALIFIER_I(qual), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .FIRST_COUNTER_IRQ_O(irq1),
        .SECOND_COUNTER_IRQ_O(irq2), .COMBINED_COUNTER_IRQ_O(comb));
    // read and compare one register
    task automatic ck(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] d;
        host.rd(a, d);
        check_count++;
        if (d !== e) begin
            err_total++;
            $display("[FAIL] %0t read %h got %h want %h", $time, a, d, e);
        end
    endtask
    // compare {combined, second, first} irq pins once settled
    task automatic ckp(input logic [2:0] e);
        repeat (2) @(posedge clk);
        @(negedge clk);
        check_count++;
        if ({comb, irq2, irq1} !== e) begin
            err_total++;
            $display("[FAIL] %0t irq pins %b want %b", $time, {comb, irq2, irq1}, e);
        end
    endtask
    // exactly n qualified edges for counter t
    task automatic step(input int t, input int n);
        @(negedge clk);
        qual[t] = 1'h1;
        repeat (n) @(posedge clk);
        @(negedge clk);
        qual[t] = 1'h0;
    endtask
    task automatic t_reset();
        logic [11:0] b;
        for (int i = 0; i < 2; i++) begin
            b = (i == 0) ? 12'h000 : 12'h020;
            ck(b, 32'h0);
            ck(b + 12'h004, 32'hFFFFFFFF);
            ck(b + 12'h008, 32'h20);
            ck(b + 12'h010, 32'h0);
            ck(b + 12'h014, 32'h0);
            ck(b + 12'h018, 32'h0);
        end
        ck(12'hF00, 32'h0);
        ck(12'h040, 32'h0);
        $display("reset values done");
    endtask
    task automatic t_load();
        host.wr(12'h000, 32'h5);
        step(0, 1);
        ck(12'h004, 32'h5);
        host.wr(12'h000, 32'h6);
        ck(12'h004, 32'h5);
        step(0, 1);
        ck(12'h004, 32'h6);
        host.wr(12'h018, 32'h9);
        step(0, 2);
        ck(12'h004, 32'h6);
        ck(12'h000, 32'h9);
        ck(12'h018, 32'h9);
        host.wr(12'h004, 32'h1234);
        ck(12'h004, 32'h6);
        $display("load paths done");
    endtask
    task automatic t_periodic();
        host.wr(12'h000, 32'h3);
        host.wr(12'h018, 32'h7);
        host.setctl(12'h000, 8'hE2);
        step(0, 1);
        ck(12'h004, 32'h3);
        step(0, 3);
        ck(12'h004, 32'h0);
        ck(12'h010, 32'h1);
        ckp(3'h5);
        step(0, 1);
        ck(12'h004, 32'h7);
        host.wr(12'h00C, 32'h0);
        ck(12'h010, 32'h0);
        ckp(3'h0);
        step(0, 7);
        ck(12'h014, 32'h1);
        host.setctl(12'h000, 8'hC2);
        ck(12'h010, 32'h1);
        ck(12'h014, 32'h0);
        ckp(3'h0);
        host.wr(12'h00C, 32'h0);
        host.setctl(12'h000, 8'h20);
        step(0, 3);
        ck(12'h004, 32'h0);
        $display("periodic reload done");
    endtask
    task automatic t_modes();
        host.wr(12'h020, 32'h00010001);
        host.setctl(12'h020, 8'h80);
        step(1, 2);
        ck(12'h024, 32'h00010000);
        ck(12'h030, 32'h1);
        step(1, 1);
        ck(12'h024, 32'h0001FFFF);
        host.wr(12'h020, 32'h0);
        host.setctl(12'h020, 8'h82);
        step(1, 2);
        ck(12'h024, 32'hFFFFFFFF);
        host.wr(12'h020, 32'h1);
        host.setctl(12'h020, 8'h83);
        step(1, 5);
        ck(12'h024, 32'h0);
        host.wr(12'h02C, 32'h0);
        ck(12'h030, 32'h0);
        host.setctl(12'h020, 8'h20);
        $display("count modes done");
    endtask
    task automatic t_prescale();
        for (int c = 0; c < 3; c++) begin
            host.wr(12'h000, 32'h1000);
            host.setctl(12'h000, 8'h82 | 8'(c << 2));
            step(0, 1);
            step(0, 16 << (4 * c));
            ck(12'h004, 32'h0FF0);
        end
        host.setctl(12'h000, 8'h20);
        $display("prescale done");
    endtask
    task automatic t_test();
        host.wr(12'hF00, 32'h1);
        host.wr(12'hF04, 32'h1);
        ckp(3'h5);
        host.wr(12'hF04, 32'h2);
        ckp(3'h6);
        host.wr(12'hF04, 32'h0);
        ckp(3'h0);
        ck(12'hF00, 32'h1);
        ck(12'hF04, 32'h0);
        host.wr(12'hF04, 32'h3);
        host.wr(12'hF00, 32'h0);
        ckp(3'h0);
        $display("test mode done");
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // main sequence after a 20-cycle reset
    initial begin
        repeat (20) @(negedge clk);
        rst = 1'h0;
        t_reset();
        t_load();
        t_periodic();
        t_modes();
        t_prescale();
        t_test();
        close_out();
    end
    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        close_out();
    end
endmodule
`default_nettype wire
